// file: bench/lpm_ctrl_assertions.sv
// Checker for the low-power mode controller, bound to its ports.
// Assumes one clock domain and the one-hot mode encoding of the package.
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl_chk
    import lpm_pkg::*;
#(
    parameter int OSC_STAB_CYC = LPM_OSC_STAB_CYC
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic wait_instr_in,
    input wire logic stop_instr_in,
    input wire logic stop_enable_in,
    input wire logic osc_run_in_stop_in,
    input wire logic lvm_off_in_wait_in,
    input wire logic cpu_clk_en_out,
    input wire logic bus_clk_en_out,
    input wire logic low_voltage_monitor_en_out,
    input wire logic conv_en_out,
    input wire logic conv_abort_out,
    input wire logic int_mask_clear_out,
    input wire logic [3:0] mode_out
);
    // Counts cycles spent stabilising, since the full delay is too long for a repetition.
    logic [15:0] stab_cnt;
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stab_cnt <= 16'h0000;
        end else if (mode_out == LPM_STAB) begin
            stab_cnt <= stab_cnt + 16'h0001;
        end else begin
            stab_cnt <= 16'h0000;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    a_cpu_clk_gate:
        assert property (mode_out == LPM_WAIT |-> !cpu_clk_en_out && bus_clk_en_out)
            else $error("cpu clock gate");
    a_wait_entry:
        assert property (mode_out == LPM_RUN && wait_instr_in && !(stop_instr_in && stop_enable_in)
            |=> mode_out == LPM_WAIT) else $error("wait entry");
    a_stop_entry_abort:
        assert property (mode_out == LPM_RUN && stop_instr_in && stop_enable_in
            |=> mode_out == LPM_STOP && conv_abort_out) else $error("stop entry");
    a_mask_clear_pulse:
        assert property (int_mask_clear_out |-> mode_out == LPM_RUN
            ##1 (mode_out == LPM_WAIT || mode_out == LPM_STOP)) else $error("mask clear");
    a_bus_in_stop:
        assert property (mode_out == LPM_STOP |-> bus_clk_en_out == osc_run_in_stop_in)
            else $error("bus clock in stop");
    a_monitor_in_wait:
        assert property (mode_out == LPM_WAIT
            |-> low_voltage_monitor_en_out == !lvm_off_in_wait_in)
            else $error("monitor in wait");
    a_conv_off_stop:
        assert property (mode_out inside {LPM_STOP, LPM_STAB} |-> !conv_en_out)
            else $error("converter in stop");
    a_stab_hold:
        assert property ($rose(mode_out == LPM_STAB)
            |-> (mode_out == LPM_STAB && !cpu_clk_en_out)[*3])
            else $error("stabilisation cut short");
    a_stab_length:
        assert property ($fell(mode_out == LPM_STAB) |-> stab_cnt == 16'(OSC_STAB_CYC + 1))
            else $error("stabilisation length");
endmodule
bind lpm_ctrl lpm_ctrl_chk #(.OSC_STAB_CYC(OSC_STAB_CYC)) u_chk (.*);
`default_nettype wire

// file: bench/lpm_ctrl_tb.sv
// Self-checking bench for the low-power mode controller.
// Assumes a short stabilisation count; inputs change at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl_tb;
    import lpm_pkg::*;
    logic clock_in = 0, rst_b_in = 0, wait_instr_in = 0, stop_instr_in = 0, stop_enable_in = 1;
    logic osc_run_in_stop_in = 0, lvm_off_in_wait_in = 0, tb_off_in_wait_in = 0, fire = 0;
    logic break_enable_in = 1, ext_irq_enable_in = 1, break_flag_clear_in = 0, ext_irq_pin_in;
    logic conv_done_irq_in, break_irq_in, periph_irq_in, cpu_clk_en_out, bus_clk_en_out;
    logic low_voltage_monitor_en_out, timebase_en_out, conv_en_out, conv_abort_out;
    logic break_unit_en_out, break_during_wait_flag_out, int_mask_clear_out, wake_out;
    logic [4:0] conv_channel_select_in = 5'h1f;
    logic [1:0] src = 0;
    logic [15:0] wake_vector_out;
    logic [3:0] mode_out;
    localparam int STAB_CYC = 4;
    // Settling time left to the converter after stop; its length is a free choice here.
    localparam int CONV_PERIOD = 16;
    logic [2:0] far_irq;
    int n_fail = 0, checks_done = 0, seed = 23, k;
    always #2.5 clock_in = ~clock_in;
    lpm_far far (.clock_in(clock_in), .fire_in(fire), .src_in(src), .pin_out(ext_irq_pin_in),
        .irq_out(far_irq));
    assign {periph_irq_in, break_irq_in, conv_done_irq_in} = far_irq;
    lpm_ctrl #(.OSC_STAB_CYC(STAB_CYC)) DUT (.*);
    // ==========================================
    // Tasks
    // ==========================================
    task chk(input string n, input logic [19:0] e, input logic [19:0] s);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task hold(input logic need);
        for (k = 0; k < 20 && wake_out !== 1'b1; k++) @(negedge clock_in);
        if (need && wake_out !== 1'b1) begin
            $display("[FAIL] wake expected 1 seen 0");
            n_fail++;
            conclude;
        end
    endtask
    task fire_src(input logic [1:0] s);
        src = s;
        fire = 1;
        @(negedge clock_in);
        fire = 0;
    endtask
    // Converter and other peripheral requests must not end stop; the pin and break do.
    task run(input logic stp, input logic [1:0] s);
        logic wk;
        wk = !(stp && s[0]);
        @(negedge clock_in);
        osc_run_in_stop_in = 1'($random(seed));
        lvm_off_in_wait_in = 1'($random(seed));
        tb_off_in_wait_in = 1'($random(seed));
        conv_channel_select_in = s == 2'h1 ? 5'({$random(seed)} % 31) : LPM_CONV_OFF;
        wait_instr_in = !stp;
        stop_instr_in = stp;
        #1 chk("mask_clear", 1, int_mask_clear_out);
        @(negedge clock_in);
        wait_instr_in = 0;
        stop_instr_in = 0;
        chk("mode", stp ? LPM_STOP : LPM_WAIT, mode_out);
        chk("clocks", {!stp || osc_run_in_stop_in, 1'b0},
            {bus_clk_en_out, cpu_clk_en_out});
        chk("conv", {!stp, stp}, {conv_en_out, conv_abort_out});
        if (!stp) chk("wait_units", {!lvm_off_in_wait_in, !tb_off_in_wait_in, 1'b1},
            {low_voltage_monitor_en_out, timebase_en_out, break_unit_en_out});
        else chk("break_stop", 0, break_unit_en_out);
        fire_src(s);
        hold(wk);
        if (!wk) begin
            chk("no_wake", 0, wake_out);
            fire_src(2'h0);
            hold(1);
        end
        chk("wake_cycles", 20'(stp ? STAB_CYC + 2 : 1), 20'(k));
        chk("resume", {2'b11, LPM_RUN}, {cpu_clk_en_out, conv_en_out, mode_out});
        if (!s[0] || !wk)
            chk("vector", s == 2'h2 ? LPM_VEC_BREAK : LPM_VEC_IRQ, wake_vector_out);
        if (s == 2'h2) begin
            chk("flag", 1, break_during_wait_flag_out);
            break_flag_clear_in = 1;
            @(negedge clock_in);
            break_flag_clear_in = 0;
            @(negedge clock_in);
            chk("flag_clr", 0, break_during_wait_flag_out);
        end
        if (stp) repeat (CONV_PERIOD) @(negedge clock_in);
        $display("case stop=%0d source=%0d done", stp, s);
    endtask
    initial begin
        repeat (3) @(negedge clock_in);
        rst_b_in = 1;
        for (int i = 0; i < 8; i++) run(i[2], i[1:0]);
        @(negedge clock_in);
        stop_enable_in = 0;
        stop_instr_in = 1;
        @(negedge clock_in);
        stop_instr_in = 0;
        stop_enable_in = 1;
        chk("refused", LPM_RUN, mode_out);
        wait_instr_in = 1;
        @(negedge clock_in);
        wait_instr_in = 0;
        // Disabled break and masked pin must both leave the block asleep.
        break_enable_in = 0;
        ext_irq_enable_in = 0;
        fire_src(2'h2);
        chk("break_off", 0, break_unit_en_out);
        fire_src(2'h0);
        hold(0);
        chk("masked", {1'b0, LPM_WAIT}, {wake_out, mode_out});
        rst_b_in = 0;
        #1 chk("reset", {LPM_RUN, LPM_VEC_RESET}, {mode_out, wake_vector_out});
        @(negedge clock_in);
        break_enable_in = 1;
        ext_irq_enable_in = 1;
        rst_b_in = 1;
        @(negedge clock_in);
        chk("after_reset", {2'b10, LPM_RUN}, {cpu_clk_en_out, wake_out, mode_out});
        $display("refusal and reset done");
        conclude;
    end
endmodule
`default_nettype wire

// file: bench/lpm_far.sv
// Wake sources of the far side: external pin, converter, break, other peripherals.
// Assumes fire_in is held one cycle; src_in picks the source.
`timescale 1ns/100ps
`default_nettype none
module lpm_far (
    input wire logic clock_in,
    input wire logic fire_in,
    input wire logic [1:0] src_in,
    output logic pin_out,
    output logic [2:0] irq_out
);
    // The pin idles high, so one low cycle is one falling edge.
    initial pin_out = 1'b1;
    initial irq_out = 3'h0;
    always @(posedge clock_in) begin
        pin_out <= !(fire_in && src_in == 2'h0);
        irq_out <= {3{fire_in}} & {src_in == 2'h3, src_in == 2'h2, src_in == 2'h1};
    end
endmodule
`default_nettype wire

// file: common/lpm_pkg.sv
// Constants, states and vectors for the low-power mode controller.
// Assumes a single 200 MHz clock domain.
package lpm_pkg;
    // ==========================================
    // Timing
    // ==========================================
    localparam int LPM_CLK_PERIOD_PS = 5000;
    localparam int LPM_OSC_STAB_NS = 20000;
    localparam int LPM_OSC_STAB_CYC = (LPM_OSC_STAB_NS * 1000 + LPM_CLK_PERIOD_PS - 1)
        / LPM_CLK_PERIOD_PS;
    localparam int LPM_CNT_W = 16;
    // ==========================================
    // Vectors and converter-off channel code
    // ==========================================
    localparam logic [15:0] LPM_VEC_RESET = 16'hfffe;
    localparam logic [15:0] LPM_VEC_IRQ = 16'hfffa;
    localparam logic [15:0] LPM_VEC_BREAK = 16'hfffc;
    localparam logic [4:0] LPM_CONV_OFF = 5'h1f;
    // ==========================================
    // States
    // ==========================================
    typedef enum logic [3:0] {
        LPM_RUN = 4'h1,
        LPM_WAIT = 4'h2,
        LPM_STOP = 4'h4,
        LPM_STAB = 4'h8
    } lpm_state_type;
endpackage

// file: hw/lpm_ctrl.sv
// Low-power mode controller: wait and stop entry, clock gating, wake handling.
// Assumes the CPU pulses wait/stop strobes for one cycle when the instruction executes,
// and that wake inputs are synchronous to clock_in.
// Behaviour
// (RQ1) Only two modes, wait and stop, each entered by its instruction strobe.
// (RQ2) Wait gates the CPU clock, bus clock keeps running.
// (RQ3) Config bits may switch off voltage monitor and timebase in wait.
// (RQ4) Stop gates CPU clock; bus clock too unless oscillator runs in stop.
// (RQ5) Converter runs in wait; its enabled completion interrupt wakes from wait.
// (RQ6) Software powers converter down with all channel bits one before wait.
// (RQ7) Stop makes converter inactive and aborts a conversion in progress.
// (RQ8) After external-interrupt stop exit the converter resumes by itself.
// (RQ9) Software waits one conversion period after stop before trusting results.
// (RQ10) Break stays active in wait; handler may adjust return address using flag.
// (RQ11) Break inactive in stop, but break ends stop and sets the flag.
// (RQ12) Stop leaves all break unit registers unchanged.
// (RQ13) Wait clears the mask; stays clear on interrupt wake, set on reset.
// (RQ14) Stop clears the mask; stays clear on interrupt wake, set on reset.
// (RQ15) CPU clock restarts after stop only once stabilisation delay elapses.
// (RQ16) Reset pin low resets from any mode and vectors to the reset address.
// (RQ17) External interrupt falling edge ends wait and vectors to its address.
// (RQ18) Any wake leaves the mode, ungates clocks, hands over via its sequence.
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int OSC_STAB_CYC = LPM_OSC_STAB_CYC
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic wait_instr_in,
    input wire logic stop_instr_in,
    input wire logic stop_enable_in,
    input wire logic osc_run_in_stop_in,
    input wire logic lvm_off_in_wait_in,
    input wire logic tb_off_in_wait_in,
    input wire logic [4:0] conv_channel_select_in,
    input wire logic conv_done_irq_in,
    input wire logic break_enable_in,
    input wire logic break_irq_in,
    input wire logic ext_irq_pin_in,
    input wire logic ext_irq_enable_in,
    input wire logic periph_irq_in,
    input wire logic break_flag_clear_in,
    output logic cpu_clk_en_out,
    output logic bus_clk_en_out,
    output logic low_voltage_monitor_en_out,
    output logic timebase_en_out,
    output logic conv_en_out,
    output logic conv_abort_out,
    output logic break_unit_en_out,
    output logic break_during_wait_flag_out,
    output logic int_mask_clear_out,
    output logic wake_out,
    output logic [15:0] wake_vector_out,
    output logic [3:0] mode_out
);
    // ==========================================
    // Mode state
    // ==========================================
    lpm_state_type state;
    lpm_state_type next_state;
    logic irq_pin_d;
    logic bw_flag;
    logic next_bw_flag;
    logic wake;
    logic next_wake;
    logic [15:0] vec;
    logic [15:0] next_vec;
    logic abort;
    logic next_abort;
    logic stab_start;
    logic stab_done;
    logic irq_fall;
    logic wait_wake;

    assign irq_fall = irq_pin_d & ~ext_irq_pin_in & ext_irq_enable_in;
    // Converter wakes only when powered; all channel bits set means it is off. (RQ5)
    assign wait_wake = irq_fall | periph_irq_in | (break_irq_in & break_enable_in) |
        (conv_done_irq_in & (conv_channel_select_in != LPM_CONV_OFF)); // RQ5

    always_comb begin
        next_state = state;
        next_bw_flag = bw_flag;
        next_wake = 1'b0;
        next_vec = vec;
        next_abort = 1'b0;
        stab_start = 1'b0;
        if (break_flag_clear_in) begin
            next_bw_flag = 1'b0;
        end
        case (state)
            LPM_RUN: begin
                if (stop_instr_in && stop_enable_in) begin
                    next_state = LPM_STOP; // RQ1
                    next_abort = 1'b1; // RQ7
                end else if (wait_instr_in) begin
                    next_state = LPM_WAIT; // RQ1
                end
            end
            LPM_WAIT: begin
                if (wait_wake) begin
                    next_state = LPM_RUN; // RQ18
                    next_wake = 1'b1;
                    if (irq_fall) begin
                        next_vec = LPM_VEC_IRQ; // RQ17
                    end else if (break_irq_in && break_enable_in) begin
                        next_vec = LPM_VEC_BREAK;
                        next_bw_flag = 1'b1; // RQ10
                    end else begin
                        next_vec = vec;
                    end
                end
            end
            LPM_STOP: begin
                // Only external interrupt and break can end stop; peripherals are halted.
                if (irq_fall || break_irq_in) begin
                    next_state = LPM_STAB;
                    stab_start = 1'b1;
                    next_vec = irq_fall ? LPM_VEC_IRQ : LPM_VEC_BREAK;
                    if (!irq_fall) begin
                        next_bw_flag = 1'b1; // RQ11
                    end
                end
            end
            LPM_STAB: begin
                if (stab_done) begin
                    next_state = LPM_RUN; // RQ15
                    next_wake = 1'b1; // RQ18
                end
            end
            default: begin
                next_state = LPM_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= LPM_RUN; // RQ16
            irq_pin_d <= 1'b1;
            bw_flag <= 1'b0;
            wake <= 1'b0;
            vec <= LPM_VEC_RESET; // RQ16
            abort <= 1'b0;
        end else begin
            state <= next_state;
            irq_pin_d <= ext_irq_pin_in;
            bw_flag <= next_bw_flag;
            wake <= next_wake;
            vec <= next_vec;
            abort <= next_abort;
        end
    end

    lpm_stab_timer #(
        .COUNT(OSC_STAB_CYC),
        .W(LPM_CNT_W)
    ) u_stab (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .start_in(stab_start),
        .done_out(stab_done)
    );

    // ==========================================
    // Outputs
    // ==========================================
    // Clock enables are combinational so gating starts in the cycle after the strobe.
    assign cpu_clk_en_out = (state == LPM_RUN); // RQ2 RQ4 RQ15
    assign bus_clk_en_out = !((state == LPM_STOP || state == LPM_STAB) &&
        !osc_run_in_stop_in); // RQ4
    assign low_voltage_monitor_en_out = !(state == LPM_WAIT && lvm_off_in_wait_in); // RQ3
    assign timebase_en_out = !(state == LPM_WAIT && tb_off_in_wait_in); // RQ3
    // Converter turns back on by itself once stop ends. (RQ8)
    assign conv_en_out = !(state == LPM_STOP || state == LPM_STAB); // RQ7 RQ8
    assign conv_abort_out = abort; // RQ7
    // Break registers are never touched here; only its enable is gated. (RQ12)
    assign break_unit_en_out = break_enable_in &&
        !(state == LPM_STOP || state == LPM_STAB); // RQ10 RQ11 RQ12
    assign break_during_wait_flag_out = bw_flag;
    // Clear pulse on entry; the reset of the CPU itself sets the mask again.
    assign int_mask_clear_out = (state == LPM_RUN) &&
        ((stop_instr_in && stop_enable_in) || wait_instr_in); // RQ13 RQ14
    assign wake_out = wake;
    assign wake_vector_out = vec;
    assign mode_out = state;
endmodule
`default_nettype wire

// file: hw/lpm_stab_timer.sv
// Oscillator stabilisation counter for the stop-mode exit.
// Assumes start_in is a one-cycle pulse; done_out pulses once when the count ends.
`timescale 1ns/100ps
`default_nettype none
module lpm_stab_timer #(
    parameter int COUNT = 4000,
    parameter int W = 16
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    output logic done_out
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic busy;
    logic next_busy;
    logic done;
    logic next_done;

    always_comb begin
        next_count = count;
        next_busy = busy;
        next_done = 1'b0;
        if (start_in) begin
            next_count = W'(COUNT - 1);
            next_busy = 1'b1;
        end else if (busy) begin
            if (count == '0) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = count - 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign done_out = done;
endmodule
`default_nettype wire
